/* common/bal_alu_if.sv */
`timescale 1ns/1ps
interface bal_alu_if;
    bal_pkg::bal_op_e op;
    logic [7:0]       dst;
    logic [7:0]       dst_hi;
    logic [7:0]       src;
    logic [7:0]       konst;
    logic [7:0]       flags;
    logic [7:0]       res;
    logic [7:0]       res_hi;
    logic [7:0]       new_flags;
    logic [7:0]       upd_mask;
    logic             word;

    modport core (input op, dst, dst_hi, src, konst, flags,
                  output res, res_hi, new_flags, upd_mask, word);
    modport ctrl (output op, dst, dst_hi, src, konst, flags,
                  input res, res_hi, new_flags, upd_mask, word);
endinterface

/* common/bal_pkg.sv */
package bal_pkg;

    // ----------------------------------------
    // widths and timing
    // ----------------------------------------
    localparam int DATA_W      = 8;
    localparam int BUS_W       = 32;
    localparam int BYTE_CYCLES = 1;
    localparam int WORD_CYCLES = 2;
    localparam logic [1:0] WORD_WAIT = 2'(WORD_CYCLES - BYTE_CYCLES);
    localparam logic [1:0] LAST_WAIT = 2'h1;

    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_DEST   = 8'h00;
    localparam logic [7:0] OFS_SRC    = 8'h04;
    localparam logic [7:0] OFS_CONST  = 8'h08;
    localparam logic [7:0] OFS_DESTHI = 8'h0C;
    localparam logic [7:0] OFS_CTRL   = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // ----------------------------------------
    // flag positions, masks and reset values
    // ----------------------------------------
    localparam int FLAG_C   = 0;
    localparam int FLAG_Z   = 1;
    localparam int FLAG_N   = 2;
    localparam int FLAG_V   = 3;
    localparam int FLAG_S   = 4;
    localparam int FLAG_H   = 5;
    localparam int BUSY_BIT = 8;
    localparam int OPC_W    = 5;
    localparam logic [7:0] MASK_ARITH = 8'h2F;
    localparam logic [7:0] MASK_WORD  = 8'h1F;
    localparam logic [7:0] MASK_LOGIC = 8'h0E;
    localparam logic [7:0] MASK_COMPL = 8'h0F;
    localparam logic [7:0] ALL_ONES   = 8'hFF;
    localparam logic [7:0] ONE_BYTE   = 8'h01;
    localparam logic [7:0] DATA_RST   = 8'h00;
    localparam logic [7:0] FLAGS_RST  = 8'h00;

    // ----------------------------------------
    // operations
    // ----------------------------------------
    typedef enum logic [4:0] {
        OP_ADD, OP_ADC, OP_SUB, OP_SUBTRACT_BORROW_REGS,
        OP_SUBTRACT_IMMEDIATE, OP_SUBTRACT_BORROW_CONST,
        OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE,
        OP_AND, OP_AND_WITH_CONSTANT, OP_OR, OP_OR_WITH_CONSTANT,
        OP_EXCLUSIVE_OR_REGISTERS, OP_COM, OP_ARITH_INVERSE,
        OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK, OP_INC, OP_MINUS_ONE
    } bal_op_e;
    localparam logic [4:0] OP_COUNT = 5'h13;

endpackage

/* hw/bal_alu_core.sv */
`timescale 1ns/1ps
module bal_alu_core (
    bal_alu_if.core alu
);
    always_comb begin
        logic [7:0]  a;
        logic [7:0]  b;
        logic [7:0]  r;
        logic [8:0]  s9;
        logic [16:0] w17;
        logic        cin;
        logic        sub;
        logic        lg;
        logic        cy;
        logic        vv;
        logic        hc;
        a   = alu.dst;
        b   = alu.src;
        r   = bal_pkg::DATA_RST;
        cin = 1'b0;
        sub = 1'b0;
        lg  = 1'b0;
        cy  = 1'b0;
        vv  = 1'b0;
        hc  = 1'b0;
        s9  = 9'h000;
        w17 = 17'h0_0000;
        alu.word     = 1'b0;
        alu.upd_mask = bal_pkg::MASK_ARITH;
        case (alu.op)
            bal_pkg::OP_ADD: begin end
            bal_pkg::OP_ADC: cin = alu.flags[bal_pkg::FLAG_C];
            bal_pkg::OP_SUB: sub = 1'b1;
            bal_pkg::OP_SUBTRACT_BORROW_REGS: begin
                sub = 1'b1;
                cin = alu.flags[bal_pkg::FLAG_C];
            end
            bal_pkg::OP_SUBTRACT_IMMEDIATE: begin
                sub = 1'b1;
                b   = alu.konst;
            end
            bal_pkg::OP_SUBTRACT_BORROW_CONST: begin
                sub = 1'b1;
                b   = alu.konst;
                cin = alu.flags[bal_pkg::FLAG_C];
            end
            bal_pkg::OP_WORD_ADD_IMMEDIATE: begin
                alu.word     = 1'b1;
                alu.upd_mask = bal_pkg::MASK_WORD;
            end
            bal_pkg::OP_WORD_SUBTRACT_IMMEDIATE: begin
                alu.word     = 1'b1;
                sub          = 1'b1;
                alu.upd_mask = bal_pkg::MASK_WORD;
            end
            bal_pkg::OP_ARITH_INVERSE: begin
                sub = 1'b1;
                a   = bal_pkg::DATA_RST;
                b   = alu.dst;
            end
            bal_pkg::OP_INC: begin
                b            = bal_pkg::ONE_BYTE;
                alu.upd_mask = bal_pkg::MASK_LOGIC;
            end
            bal_pkg::OP_MINUS_ONE: begin
                sub          = 1'b1;
                b            = bal_pkg::ONE_BYTE;
                alu.upd_mask = bal_pkg::MASK_LOGIC;
            end
            bal_pkg::OP_COM: alu.upd_mask = bal_pkg::MASK_COMPL;
            default: begin
                lg           = 1'b1;
                alu.upd_mask = bal_pkg::MASK_LOGIC;
            end
        endcase
        // byte arithmetic and its flags
        s9 = sub ? ({1'b0, a} - {1'b0, b} - {8'h00, cin}) : ({1'b0, a} + {1'b0, b} + {8'h00, cin});
        r  = s9[7:0];
        if (sub) begin
            cy = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
            hc = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
            vv = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        end else begin
            cy = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
            hc = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
            vv = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
        end
        // logic group overrides, overflow cleared
        if (lg) begin
            vv = 1'b0;
            case (alu.op)
                bal_pkg::OP_AND:  r = alu.dst & alu.src;
                bal_pkg::OP_AND_WITH_CONSTANT:      r = alu.dst & alu.konst;
                bal_pkg::OP_OR:                     r = alu.dst | alu.src;
                bal_pkg::OP_OR_WITH_CONSTANT:       r = alu.dst | alu.konst;
                bal_pkg::OP_EXCLUSIVE_OR_REGISTERS: r = alu.dst ^ alu.src;
                bal_pkg::OP_SET_BITS_MASK:          r = alu.dst | alu.konst;
                bal_pkg::OP_CLEAR_BITS_MASK:        r = alu.dst & (bal_pkg::ALL_ONES - alu.konst);
                default:          r = alu.dst;
            endcase
        end
        if (alu.op == bal_pkg::OP_COM) begin
            r  = bal_pkg::ALL_ONES - alu.dst;
            cy = 1'b1;
            vv = 1'b0;
        end
        // word arithmetic over the register pair
        w17 = sub ? ({1'b0, alu.dst_hi, alu.dst} - {9'h000, alu.konst})
                  : ({1'b0, alu.dst_hi, alu.dst} + {9'h000, alu.konst});
        alu.res    = alu.word ? w17[7:0] : r;
        alu.res_hi = w17[15:8];
        alu.new_flags = bal_pkg::FLAGS_RST;
        if (alu.word) begin
            vv = sub ? (alu.dst_hi[7] & ~w17[15]) : (~alu.dst_hi[7] & w17[15]);
            cy = sub ? (w17[15] & ~alu.dst_hi[7]) : (~w17[15] & alu.dst_hi[7]);
            alu.new_flags[bal_pkg::FLAG_Z] = (w17[15:0] == 16'h0000);
            alu.new_flags[bal_pkg::FLAG_N] = w17[15];
        end else begin
            alu.new_flags[bal_pkg::FLAG_Z] = (r == bal_pkg::DATA_RST);
            alu.new_flags[bal_pkg::FLAG_N] = r[7];
        end
        alu.new_flags[bal_pkg::FLAG_C] = cy;
        alu.new_flags[bal_pkg::FLAG_V] = vv;
        alu.new_flags[bal_pkg::FLAG_H] = hc;
        alu.new_flags[bal_pkg::FLAG_S] = alu.new_flags[bal_pkg::FLAG_N] ^ vv;
    end
endmodule

/* hw/bal_top.sv */
// Operation
// - Add source to destination, with carry optional, update Z C N V H, one cycle.
// - Subtract source from destination, with carry optional, update Z C N V H, one cycle.
// - Subtract the constant from the destination, update Z C N V H, one cycle.
// - Subtract the constant and the carry from the destination, update Z C N V H, one cycle.
// - Add the constant to the 16-bit pair, write both halves, update Z C N V S, two cycles.
// - Subtract the constant from the 16-bit pair, write both halves, update Z C N V S, two cycles.
// - AND with source or constant into destination, update only Z N V, one cycle.
// - OR with source or constant, or XOR with source, into destination, update Z N V, one cycle.
// - Set bits by OR-ing the mask into destination, update Z N V, one cycle.
// - Clear bits by AND-ing with all-ones minus the mask, update Z N V, one cycle.
`timescale 1ns/1ps
module bal_top (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hwdata_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic      [7:0]  flags_o,
    output logic             busy_o
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0]  dst;
    logic [7:0]  dst_hi;
    logic [7:0]  src;
    logic [7:0]  konst;
    logic [7:0]  flags;
    logic [7:0]  hi_pend;
    logic [7:0]  flags_pend;
    logic [7:0]  mask_pend;
    logic [4:0]  last_op;
    logic [1:0]  busy_cnt;
    logic        dp_valid;
    logic        dp_write;
    logic [7:0]  dp_addr;
    logic        busy;
    logic        accept;
    logic        wr_en;
    logic        exec;
    logic        commit;
    logic        op_ok;
    logic [7:0]  wdat;
    logic [31:0] rdat;
    logic [15:0] word_val;
    logic        carry_f;
    logic        zero_f;
    logic        ovf_f;
    logic [2:0]  size_seen;

    bal_alu_if alu ();

    bal_alu_core u_core (
        .alu (alu)
    );

    // ----------------------------------------
    // bus slave: address and data phase
    // ----------------------------------------
    assign busy        = (busy_cnt != 2'h0);
    assign commit      = (busy_cnt == bal_pkg::LAST_WAIT);
    assign hreadyout_o = ~busy;
    assign hresp_o     = 1'b0;
    assign accept      = hsel_i & htrans_i[1] & hready_i;
    assign wr_en       = dp_valid & dp_write & ~busy;
    assign wdat        = hwdata_i[7:0];
    assign op_ok       = (hwdata_i[4:0] < bal_pkg::OP_COUNT);
    assign exec        = wr_en & (dp_addr == bal_pkg::OFS_CTRL) & op_ok;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            dp_valid  <= 1'b0;
            dp_write  <= 1'b0;
            dp_addr   <= 8'h00;
            size_seen <= 3'h0;
        end else if (hready_i) begin
            dp_valid  <= accept;
            dp_write  <= hwrite_i;
            dp_addr   <= haddr_i[7:0];
            size_seen <= hsize_i;
        end
    end

    always_comb begin
        rdat = 32'h0000_0000;
        case (dp_addr)
            bal_pkg::OFS_DEST:   rdat[7:0] = dst;
            bal_pkg::OFS_SRC:    rdat[7:0] = src;
            bal_pkg::OFS_CONST:  rdat[7:0] = konst;
            bal_pkg::OFS_DESTHI: rdat[7:0] = dst_hi;
            bal_pkg::OFS_CTRL:   rdat[4:0] = last_op;
            bal_pkg::OFS_STATUS: begin
                rdat[7:0]               = flags;
                rdat[bal_pkg::BUSY_BIT] = busy;
            end
            default:             rdat = 32'h0000_0000;
        endcase
    end

    assign hrdata_o = (dp_valid & ~dp_write) ? rdat : 32'h0000_0000;

    // ----------------------------------------
    // operands to the datapath
    // ----------------------------------------
    assign alu.op     = bal_pkg::bal_op_e'(hwdata_i[4:0]);
    assign alu.dst    = dst;
    assign alu.dst_hi = dst_hi;
    assign alu.src    = src;
    assign alu.konst  = konst;
    assign alu.flags  = flags;

    // ----------------------------------------
    // operand registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            src   <= bal_pkg::DATA_RST;
            konst <= bal_pkg::DATA_RST;
        end else if (wr_en) begin
            if (dp_addr == bal_pkg::OFS_SRC) begin
                src <= wdat;
            end
            if (dp_addr == bal_pkg::OFS_CONST) begin
                konst <= wdat;
            end
        end
    end

    // destination low byte, byte results and word low half
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            dst <= bal_pkg::DATA_RST;
        end else if (exec) begin
            dst <= alu.res;
        end else if (wr_en && dp_addr == bal_pkg::OFS_DEST) begin
            dst <= wdat;
        end
    end

    // destination high byte, written in the second word cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            dst_hi <= bal_pkg::DATA_RST;
        end else if (commit) begin
            dst_hi <= hi_pend;
        end else if (wr_en && dp_addr == bal_pkg::OFS_DESTHI) begin
            dst_hi <= wdat;
        end
    end

    // ----------------------------------------
    // word sequencing
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            busy_cnt <= 2'h0;
        end else if (exec && alu.word) begin
            busy_cnt <= bal_pkg::WORD_WAIT;
        end else if (busy) begin
            busy_cnt <= busy_cnt - 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hi_pend    <= bal_pkg::DATA_RST;
            flags_pend <= bal_pkg::FLAGS_RST;
            mask_pend  <= bal_pkg::FLAGS_RST;
        end else if (exec && alu.word) begin
            hi_pend    <= alu.res_hi;
            flags_pend <= alu.new_flags;
            mask_pend  <= alu.upd_mask;
        end
    end

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            flags <= bal_pkg::FLAGS_RST;
        end else if (commit) begin
            flags <= (flags & ~mask_pend) | (flags_pend & mask_pend);
        end else if (exec && !alu.word) begin
            flags <= (flags & ~alu.upd_mask) | (alu.new_flags & alu.upd_mask);
        end else if (wr_en && dp_addr == bal_pkg::OFS_STATUS) begin
            flags <= wdat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            last_op <= 5'h00;
        end else if (exec) begin
            last_op <= hwdata_i[4:0];
        end
    end

    assign flags_o = flags;
    assign busy_o  = busy;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    assign word_val = {dst_hi, dst};
    assign carry_f  = flags[bal_pkg::FLAG_C];
    assign zero_f   = flags[bal_pkg::FLAG_Z];
    assign ovf_f    = flags[bal_pkg::FLAG_V];

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    a_add_sum: assert property (
        exec && alu.op == bal_pkg::OP_ADD |=> dst == 8'($past(dst) + $past(src)) && !busy)
        else $error("add result wrong");

    a_sub_diff: assert property (
        exec && alu.op == bal_pkg::OP_SUBTRACT_BORROW_REGS
        |=> dst == 8'($past(dst) - $past(src) - $past(carry_f)))
        else $error("subtract with carry result wrong");

    a_subtract_immediate_borrow: assert property (
        exec && alu.op == bal_pkg::OP_SUBTRACT_IMMEDIATE |=> carry_f == ($past(konst) > $past(dst)))
        else $error("subtract constant borrow wrong");

    a_subtract_borrow_const_value: assert property (
        exec && alu.op == bal_pkg::OP_SUBTRACT_BORROW_CONST
        |=> dst == 8'($past(dst) - $past(konst) - $past(carry_f)) && zero_f == (dst == 8'h00))
        else $error("subtract constant with carry wrong");

    a_word_add_time: assert property (
        exec && alu.op == bal_pkg::OP_WORD_ADD_IMMEDIATE |=> busy && !hreadyout_o ##1 !busy
        && word_val == 16'($past(word_val, 2) + {8'h00, $past(konst, 2)}))
        else $error("word add wrong or not two cycles");

    a_word_sub_value: assert property (
        exec && alu.op == bal_pkg::OP_WORD_SUBTRACT_IMMEDIATE
        |=> ##1 word_val == 16'($past(word_val, 2) - {8'h00, $past(konst, 2)}))
        else $error("word subtract result wrong");

    a_and_flags: assert property (
        exec && (alu.op == bal_pkg::OP_AND || alu.op == bal_pkg::OP_AND_WITH_CONSTANT)
        |=> !ovf_f && zero_f == (dst == 8'h00) && $stable(carry_f))
        else $error("and flags wrong");

    a_eor_value: assert property (
        exec && alu.op == bal_pkg::OP_EXCLUSIVE_OR_REGISTERS |=> dst == ($past(dst) ^ $past(src)))
        else $error("exclusive or result wrong");

    a_set_mask: assert property (
        exec && alu.op == bal_pkg::OP_SET_BITS_MASK |=> dst == ($past(dst) | $past(konst)))
        else $error("set bits result wrong");

    a_clear_mask: assert property (
        exec && alu.op == bal_pkg::OP_CLEAR_BITS_MASK |=> dst == ($past(dst) & ~$past(konst)))
        else $error("clear bits result wrong");

    a_compl_carry: assert property (
        exec && alu.op == bal_pkg::OP_COM |=> carry_f && !ovf_f && dst == ~$past(dst))
        else $error("complement wrong");

    a_incdec_carry: assert property (
        exec && (alu.op == bal_pkg::OP_INC || alu.op == bal_pkg::OP_MINUS_ONE) |=> carry_f == $past(carry_f))
        else $error("increment changed carry");

    a_adc_sum: assert property (
        exec && alu.op == bal_pkg::OP_ADC |=> dst == 8'($past(dst) + $past(src) + $past(carry_f)))
        else $error("add with carry result wrong");

    a_sub_value: assert property (
        exec && alu.op == bal_pkg::OP_SUB
        |=> dst == 8'($past(dst) - $past(src)) && carry_f == ($past(src) > $past(dst)))
        else $error("subtract result or borrow wrong");

    a_subtract_immediate_value: assert property (
        exec && alu.op == bal_pkg::OP_SUBTRACT_IMMEDIATE |=> dst == 8'($past(dst) - $past(konst)) && !busy)
        else $error("subtract constant result wrong");

    a_word_wait: assert property (
        exec && alu.op == bal_pkg::OP_WORD_SUBTRACT_IMMEDIATE |=> !hreadyout_o ##1 hreadyout_o)
        else $error("word subtract not two cycles");

    a_byte_ready: assert property (
        exec && !alu.word |=> hreadyout_o && !busy)
        else $error("byte operation stalled the bus");

    a_or_value: assert property (
        exec && alu.op == bal_pkg::OP_OR_WITH_CONSTANT |=> dst == ($past(dst) | $past(konst)) && !ovf_f)
        else $error("or with constant wrong");

    a_neg_value: assert property (
        exec && alu.op == bal_pkg::OP_ARITH_INVERSE
        |=> dst == 8'(8'h00 - $past(dst)) && carry_f == (dst != 8'h00))
        else $error("arithmetic inverse wrong");

    c_word_add: cover property (exec && alu.op == bal_pkg::OP_WORD_ADD_IMMEDIATE ##2 !busy);
    c_adc_carry: cover property (exec && alu.op == bal_pkg::OP_ADC && carry_f);
    c_neg_zero: cover property (exec && alu.op == bal_pkg::OP_ARITH_INVERSE ##1 zero_f);
    c_back_to_back: cover property (exec ##1 exec);

endmodule

/* verif/bal_host_model.sv */
`timescale 1ns/1ps
module bal_host_model (
    input  wire logic        clk_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_i,
    output logic             hsel_o,
    output logic      [31:0] haddr_o,
    output logic      [1:0]  htrans_o,
    output logic             hwrite_o,
    output logic      [2:0]  hsize_o,
    output logic      [31:0] hwdata_o
);
    // ----------------------------------------
    // single word transfers, held until ready
    // ----------------------------------------
    initial begin
        hsel_o   = 1'b1;
        haddr_o  = 32'h0000_0000;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o  = 3'h2;
        hwdata_o = 32'h0000_0000;
    end

    task automatic wait_ready;
        do @(posedge clk_i); while (hready_i !== 1'b1);
    endtask

    task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
        haddr_o  <= {24'h00_0000, a};
        htrans_o <= 2'h2;
        hwrite_o <= wr;
        wait_ready();
        htrans_o <= 2'h0;
        hwdata_o <= d;
        wait_ready();
        q = hrdata_i;
        hwdata_o <= ~d;
    endtask
endmodule

/* verif/byte_alu_arith_logic_tb_top.sv */
`timescale 1ns/1ps
module byte_alu_arith_logic_tb_top;
    typedef struct packed {
        bal_pkg::bal_op_e op;
        logic [7:0]       d, s, k, hi, f, ed, ehi, ef;
    } bal_row_s;

    logic        clk_i;
    logic        reset_i;
    logic        hsel, hwrite, hready, hresp, busy;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  flags;
    int          n_fail;
    int          total_checks;
    bal_row_s    r;

    // ----------------------------------------
    // ordinary cases: op, d, s, k, hi, preset, dest, hi, flags
    // ----------------------------------------
    bal_row_s rows [19] = '{
        '{bal_pkg::OP_ADD, 8'h78, 8'h08, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h2C},
        '{bal_pkg::OP_ADC, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h23},
        '{bal_pkg::OP_SUB, 8'h10, 8'h20, 8'h00, 8'h00, 8'h10, 8'hF0, 8'h00, 8'h15},
        '{bal_pkg::OP_SUBTRACT_BORROW_REGS, 8'h80, 8'h00, 8'h00, 8'h00, 8'h01, 8'h7F, 8'h00, 8'h28},
        '{bal_pkg::OP_SUBTRACT_IMMEDIATE, 8'h05, 8'h00, 8'h05, 8'h00, 8'hC0, 8'h00, 8'h00, 8'hC2},
        '{bal_pkg::OP_SUBTRACT_BORROW_CONST, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'hFF, 8'h00, 8'h25},
        '{bal_pkg::OP_WORD_ADD_IMMEDIATE, 8'hFF, 8'h00, 8'h01, 8'h7F, 8'h20, 8'h00, 8'h80, 8'h2C},
        '{bal_pkg::OP_WORD_SUBTRACT_IMMEDIATE, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h15},
        '{bal_pkg::OP_AND, 8'hF0, 8'h0F, 8'h00, 8'h00, 8'h09, 8'h00, 8'h00, 8'h03},
        '{bal_pkg::OP_AND_WITH_CONSTANT, 8'hC3, 8'h00, 8'h81, 8'h00, 8'h00, 8'h81, 8'h00, 8'h04},
        '{bal_pkg::OP_OR, 8'h80, 8'h01, 8'h00, 8'h00, 8'h08, 8'h81, 8'h00, 8'h04},
        '{bal_pkg::OP_OR_WITH_CONSTANT, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02},
        '{bal_pkg::OP_EXCLUSIVE_OR_REGISTERS, 8'hAA, 8'hAA, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h02},
        '{bal_pkg::OP_COM, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h28, 8'h00, 8'h00, 8'h23},
        '{bal_pkg::OP_ARITH_INVERSE, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h25},
        '{bal_pkg::OP_SET_BITS_MASK, 8'h10, 8'h00, 8'h81, 8'h00, 8'h08, 8'h91, 8'h00, 8'h04},
        '{bal_pkg::OP_CLEAR_BITS_MASK, 8'hFF, 8'h00, 8'h0F, 8'h00, 8'h00, 8'hF0, 8'h00, 8'h04},
        '{bal_pkg::OP_INC, 8'h7F, 8'h00, 8'h00, 8'h00, 8'h21, 8'h80, 8'h00, 8'h2D},
        '{bal_pkg::OP_MINUS_ONE, 8'h80, 8'h00, 8'h00, 8'h00, 8'h01, 8'h7F, 8'h00, 8'h09}
    };

    bal_top u_dut (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .hsel_i      (hsel),
        .haddr_i     (haddr),
        .htrans_i    (htrans),
        .hwrite_i    (hwrite),
        .hsize_i     (hsize),
        .hready_i    (hready),
        .hwdata_i    (hwdata),
        .hrdata_o    (hrdata),
        .hreadyout_o (hready),
        .hresp_o     (hresp),
        .flags_o     (flags),
        .busy_o      (busy)
    );

    bal_host_model u_host (
        .clk_i    (clk_i),
        .hready_i (hready),
        .hrdata_i (hrdata),
        .hsel_o   (hsel),
        .haddr_o  (haddr),
        .htrans_o (htrans),
        .hwrite_o (hwrite),
        .hsize_o  (hsize),
        .hwdata_o (hwdata)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_host.xfer(a, 1'b1, d, q);
    endtask

    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        u_host.xfer(a, 1'b0, 32'hA5A5_5A5A, v);
        chk(n, v, e);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        report_and_stop();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        n_fail       = 0;
        total_checks = 0;
        reset_i      = 1'b1;
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        foreach (rows[i]) begin
            r = rows[i];
            w(bal_pkg::OFS_DEST, 32'(r.d));
            w(bal_pkg::OFS_SRC, 32'(r.s));
            w(bal_pkg::OFS_CONST, 32'(r.k));
            w(bal_pkg::OFS_DESTHI, 32'(r.hi));
            w(bal_pkg::OFS_STATUS, 32'(r.f));
            w(bal_pkg::OFS_CTRL, 32'(r.op));
            rc("dest", bal_pkg::OFS_DEST, 32'(r.ed));
            rc("desthi", bal_pkg::OFS_DESTHI, 32'(r.ehi));
            rc("status", bal_pkg::OFS_STATUS, 32'(r.ef));
            rc("ctrl", bal_pkg::OFS_CTRL, 32'(r.op));
            chk("flags_o", 32'(flags), 32'(r.ef));
            chk("hresp", 32'(hresp), 32'h0000_0000);
            $display("row %0d done", i);
        end
        // word op: busy in its second cycle, stalled read sees high byte
        w(bal_pkg::OFS_DEST, 32'h0000_00FF);
        w(bal_pkg::OFS_DESTHI, 32'h0000_0000);
        w(bal_pkg::OFS_CONST, 32'h0000_0001);
        w(bal_pkg::OFS_CTRL, 32'(bal_pkg::OP_WORD_ADD_IMMEDIATE));
        fork
            rc("word hi", bal_pkg::OFS_DESTHI, 32'h0000_0001);
            begin
                #1;
                chk("busy", 32'(busy), 32'h0000_0001);
                chk("hready", 32'(hready), 32'h0000_0000);
            end
        join
        rc("word lo", bal_pkg::OFS_DEST, 32'h0000_0000);
        $display("word timing done");
        // refused opcode, unmapped place, read-only busy bit
        w(bal_pkg::OFS_CTRL, 32'(bal_pkg::OP_COUNT));
        rc("refused ctrl", bal_pkg::OFS_CTRL, 32'(bal_pkg::OP_WORD_ADD_IMMEDIATE));
        w(8'h18, 32'h0000_00FF);
        rc("unmapped", 8'h18, 32'h0000_0000);
        w(bal_pkg::OFS_STATUS, 32'h0000_01FF);
        rc("status ro", bal_pkg::OFS_STATUS, 32'h0000_00FF);
        $display("refusal done");
        // back-to-back increments keep carry
        w(bal_pkg::OFS_DEST, 32'hFFFF_FFFE);
        w(bal_pkg::OFS_STATUS, 32'h0000_0001);
        w(bal_pkg::OFS_CTRL, 32'(bal_pkg::OP_INC));
        w(bal_pkg::OFS_CTRL, 32'(bal_pkg::OP_INC));
        rc("inc2 dest", bal_pkg::OFS_DEST, 32'h0000_0000);
        rc("inc2 flags", bal_pkg::OFS_STATUS, 32'h0000_0003);
        $display("back to back done");
        // reset in mid-run
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        chk("busy rst", 32'(busy), 32'h0000_0000);
        rc("dest rst", bal_pkg::OFS_DEST, 32'h0000_0000);
        rc("status rst", bal_pkg::OFS_STATUS, 32'h0000_0000);
        rc("ctrl rst", bal_pkg::OFS_CTRL, 32'h0000_0000);
        $display("reset done");
        report_and_stop();
    end
endmodule
